// ===== rtl/xmb_pkg.sv
// Shared constants and types for the external memory bus block.
// Assumes a single 50 MHz clock and an AXI4-Lite register master.
`default_nettype none

package xmb_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int AXI_AW = 10; // Byte address width
    localparam int PORT_W = 8; // Width of every pin group
    localparam logic [7:0] PORT3_MODE_IDX = 8'hF7;
    localparam logic [7:0] BUS_PORT_MODE_IDX = 8'hF8;
    localparam logic [7:0] PORT0_IDX = 8'h00;
    localparam logic [7:0] PORT1_IDX = 8'h01;
    localparam logic [7:0] BUS_ADDR_IDX = 8'h10;
    localparam logic [7:0] BUS_WDATA_IDX = 8'h11;
    localparam logic [7:0] BUS_CMD_IDX = 8'h12;
    localparam logic [7:0] BUS_STAT_IDX = 8'h13;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int PM_P0LO_HI = 1; // Low nibble mode, bit 1 = address
    localparam int PM_P0LO_LO = 0;
    localparam int PM_STACK = 2; // 1 = stack in register file
    localparam int PM_BUS_HI = 4; // Bus port mode field
    localparam int PM_BUS_LO = 3;
    localparam int PM_EXT = 5; // Extended timing
    localparam int PM_P0HI_HI = 7; // High nibble mode, bit 7 = address
    localparam int PM_P0HI_LO = 6;
    localparam int P3_DM_HI = 4; // Data space select enable field
    localparam int P3_DM_LO = 3;
    localparam logic [7:0] BUS_PORT_MODE_CONTROL_RST = 8'h4D;
    localparam logic [7:0] P3M_RST = 8'h00;
    localparam logic [15:0] RESET_VECTOR = 16'h000C;
    localparam logic [7:0] BUS_READ_VAL = 8'hFF;

    // Encodings of mode fields
    localparam logic [1:0] IO_OUT = 2'b00;
    localparam logic [1:0] AD_MODE = 2'b10;
    localparam logic [1:0] SHARED_MODE = 2'b11;
    localparam logic [1:0] DM_SEL_A = 2'b10;
    localparam logic [1:0] DM_SEL_B = 2'b01;

    // Command register fields
    localparam logic [1:0] KIND_INT = 2'b00;
    localparam logic [1:0] KIND_RD = 2'b01;
    localparam logic [1:0] KIND_WR = 2'b10;
    localparam logic [1:0] KIND_BAD = 2'b11;
    localparam int CMD_DSP = 2;
    localparam int CMD_STK = 3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // Timing counts in clock periods
    // ------------------------------------------------------------
    localparam logic [3:0] MC_CLKS = 4'h6;
    localparam logic [3:0] MC_EXT_CLKS = 4'h8;
    localparam logic [3:0] DS_CLKS = 4'h3;
    localparam logic [3:0] DS_EXT_CLKS = 4'h5;

    // Machine cycle timing states
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_T1 = 3'b001,
        BUS_T2 = 3'b010,
        BUS_TX = 3'b011,
        BUS_T3 = 3'b100
    } xmb_bus_st_t;

endpackage

`default_nettype wire

// ===== rtl/xmb_sync.sv
// Three-stage input synchroniser for an eight-bit pin group.
// Assumes pins change freely relative to the clock.
`default_nettype none

module xmb_sync
    import xmb_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [PORT_W-1:0] d_in,
    output logic [PORT_W-1:0] q_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PORT_W-1:0] s1; // Metastable stage, read by s2 only
        logic [PORT_W-1:0] s2;
        logic [PORT_W-1:0] s3;
        logic [PORT_W-1:0] q; // Filtered value
    } xmb_sync_t;

    xmb_sync_t r;
    xmb_sync_t n;

    // A bit moves only once stages two and three agree
    always_comb
    begin
        n = r;
        n.s1 = d_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.q = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
    end

    // Register the whole state
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            r <= '0;
        else
            r <= n;
    end

    assign q_out = r.q;

endmodule // xmb_sync

`default_nettype wire

// ===== rtl/xmb_port_view.sv
// Software view of the two address-capable ports.
// Assumes mode_in is the bus port mode register; purely combinational.
`default_nettype none

module xmb_port_view
    import xmb_pkg::*;
(
    input wire logic [7:0] mode_in,
    input wire logic [PORT_W-1:0] p0_pins_in,
    input wire logic [PORT_W-1:0] p1_pins_in,
    output logic [PORT_W-1:0] p0_rd_out,
    output logic [PORT_W-1:0] p0_wmask_out,
    output logic [PORT_W-1:0] p1_rd_out,
    output logic p1_wen_out
);

    // ------------------------------------------------------------
    // Nibbles taken for address read as ones and ignore writes
    // ------------------------------------------------------------
    logic [PORT_W-1:0] p0_taken;
    logic p1_taken;

    assign p0_taken = {{4{mode_in[PM_P0HI_HI]}}, {4{mode_in[PM_P0LO_HI]}}};
    assign p0_rd_out = p0_pins_in | p0_taken;
    assign p0_wmask_out = ~p0_taken;
    // Bus modes 10 and 11 both own the low port
    assign p1_taken = mode_in[PM_BUS_HI];
    assign p1_rd_out = p1_taken ? BUS_READ_VAL : p1_pins_in;
    assign p1_wen_out = ~p1_taken;

endmodule // xmb_port_view

`default_nettype wire

// ===== rtl/xmb_ext_bus.sv
// External memory bus engine with its mode registers on AXI4-Lite.
// Assumes one 50 MHz clock, a synchronous active-high reset, and
// that pin wires are resolved outside from the output enables.
`default_nettype none

// Operation
// - Address strobe pulses low each machine cycle
// - Strobes, read/write and ports can float
// - Write data valid at data strobe fall
// - Read/write low only for external writes
// - First fetch after reset at location 000C
// - Low port multiplexes address and data
// - Second port extends address to 12/16 bits
// - Mode bits 4:3 = 10 selects bus
// - Bits 1 and 7 select address nibbles
// - Bus port reads FF, ignores writes
// - Full address port leaves no register
// - Half address port reads data over F
// - Bit 2 picks stack location
// - Select output enabled by port3 modes 10/01
// - Select low for data and external stack
// - Machine cycle six or eight clocks
// - Select splits program and data spaces
// - Float bus, then sample before strobe rise
// - Extended timing adds two strobe clocks
// - Reset gives inputs, internal stack, extended; reset value 4D here leaves bit 5 clear, normal timing
// - Mode 11 floats bus for another master
module xmb_ext_bus
    import xmb_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [AXI_AW-1:0] AXI_AWADDR_IN,
    input wire logic AXI_AWVALID_IN,
    output logic AXI_AWREADY_OUT,
    input wire logic [31:0] AXI_WDATA_IN,
    input wire logic [3:0] AXI_WSTRB_IN,
    input wire logic AXI_WVALID_IN,
    output logic AXI_WREADY_OUT,
    output logic [1:0] AXI_BRESP_OUT,
    output logic AXI_BVALID_OUT,
    input wire logic AXI_BREADY_IN,
    input wire logic [AXI_AW-1:0] AXI_ARADDR_IN,
    input wire logic AXI_ARVALID_IN,
    output logic AXI_ARREADY_OUT,
    output logic [31:0] AXI_RDATA_OUT,
    output logic [1:0] AXI_RRESP_OUT,
    output logic AXI_RVALID_OUT,
    input wire logic AXI_RREADY_IN,
    output logic ADDR_STROBE_N_OUT,
    output logic ADDR_STROBE_OE_OUT,
    output logic XFER_STROBE_N_OUT,
    output logic XFER_STROBE_OE_OUT,
    output logic READ_WRITE_N_OUT,
    output logic READ_WRITE_OE_OUT,
    input wire logic [PORT_W-1:0] MUX_ADDR_DATA_BUS_IN,
    output logic [PORT_W-1:0] MUX_ADDR_DATA_BUS_OUT,
    output logic MUX_ADDR_DATA_BUS_OE_OUT,
    input wire logic [PORT_W-1:0] ADDR_PORT_IN,
    output logic [PORT_W-1:0] ADDR_PORT_OUT,
    output logic [PORT_W-1:0] ADDR_PORT_OE_OUT,
    output logic DATA_SPACE_SEL_N_OUT,
    output logic DATA_SPACE_SEL_OE_OUT
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic awrdy; // AXI channel readies
        logic wrdy;
        logic arrdy;
        logic aw_h; // Write address held
        logic w_h; // Write data held
        logic [7:0] aw_i;
        logic [15:0] wd;
        logic [1:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [1:0] rr;
        logic [15:0] rd;
        logic [7:0] bus_port_mode_control; // Bus port mode
        logic [7:0] p3m; // Port 3 mode
        logic [7:0] p0d; // Port 0 output data
        logic [7:0] p1d; // Port 1 output data
        logic [15:0] addr; // Address of next cycle
        logic [7:0] wdat; // Write data
        logic [7:0] rdat; // Last data read
        logic boot; // Reset fetch pending
        logic [1:0] kind; // Cycle kind
        logic dsp; // Data space access
        logic stk; // Stack access
        logic ext; // Cycle uses extended timing
        xmb_bus_st_t bs;
        logic ph; // Clock within state
        logic as_n;
        logic ds_n;
        logic rw;
        logic ctl_oe;
        logic dm_n;
        logic dm_oe;
        logic [7:0] ad_o;
        logic ad_oe;
        logic [7:0] p0_o;
        logic [7:0] p0_oe;
        logic [3:0] ds_cnt; // Clocks with data strobe low
        logic [3:0] cyc_cnt; // Clocks of the current cycle
    } xmb_top_st_t;

    xmb_top_st_t r;
    xmb_top_st_t n;

    logic [PORT_W-1:0] ad_sync; // Synchronised bus pins
    logic [PORT_W-1:0] p0_sync; // Synchronised port 0 pins
    logic [PORT_W-1:0] p0_rd;
    logic [PORT_W-1:0] p0_wmask;
    logic [PORT_W-1:0] p1_rd;
    logic p1_wen;
    logic busy_n; // Next state is inside a cycle
    logic ext_ref; // Next cycle goes to external memory
    logic shared; // Bus handed to another master
    logic ad_mode; // Low port is the address/data bus
    logic [1:0] resp;

    // ------------------------------------------------------------
    // Pin synchronisers and port views
    // ------------------------------------------------------------
    xmb_sync u_ad_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in(MUX_ADDR_DATA_BUS_IN),
        .q_out(ad_sync)
    );

    xmb_sync u_p0_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in(ADDR_PORT_IN),
        .q_out(p0_sync)
    );

    xmb_port_view u_view (
        .mode_in(r.bus_port_mode_control),
        .p0_pins_in(p0_sync),
        .p1_pins_in(ad_sync),
        .p0_rd_out(p0_rd),
        .p0_wmask_out(p0_wmask),
        .p1_rd_out(p1_rd),
        .p1_wen_out(p1_wen)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        n = r;
        resp = RESP_OKAY;
        // Capture write address and data in either order
        if (AXI_AWVALID_IN && r.awrdy)
        begin
            n.aw_h = 1'b1;
            n.aw_i = AXI_AWADDR_IN[9:2];
        end
        if (AXI_WVALID_IN && r.wrdy)
        begin
            n.w_h = 1'b1;
            n.wd = AXI_WDATA_IN[15:0];
            n.ws = AXI_WSTRB_IN[1:0];
        end
        if (AXI_BREADY_IN && r.bv)
            n.bv = 1'b0;
        if (AXI_RREADY_IN && r.rv)
            n.rv = 1'b0;

        // Machine cycle sequencer, two clocks per timing state
        if (r.boot)
        begin
            n.boot = 1'b0;
            n.bs = BUS_T1;
            n.ph = 1'b0;
            n.kind = KIND_INT;
            n.dsp = 1'b0;
            n.stk = 1'b0;
            n.ext = 1'b0;
        end
        else if (r.bs != BUS_IDLE)
        begin
            n.ph = ~r.ph;
            if (r.ph)
            begin
                case (r.bs)
                    BUS_T1: n.bs = BUS_T2;
                    // Extra state only for external cycles
                    BUS_T2: n.bs = r.ext ? BUS_TX : BUS_T3;
                    BUS_TX: n.bs = BUS_T3;
                    BUS_T3:
                    begin
                        n.bs = BUS_IDLE;
                        // Sampled while the strobe is still low
                        if (r.kind == KIND_RD)
                            n.rdat = ad_sync;
                    end
                    default: n.bs = BUS_IDLE;
                endcase
            end
        end

        // Register writes, one at a time
        if (r.aw_h && r.w_h && !r.bv)
        begin
            n.aw_h = 1'b0;
            n.w_h = 1'b0;
            n.bv = 1'b1;
            case (r.aw_i)
                BUS_PORT_MODE_IDX:
                    if (r.ws[0])
                        n.bus_port_mode_control = r.wd[7:0];
                PORT3_MODE_IDX:
                    if (r.ws[0])
                        n.p3m = r.wd[7:0];
                PORT0_IDX:
                    if (r.ws[0])
                        n.p0d = (r.p0d & ~p0_wmask)
                            | (r.wd[7:0] & p0_wmask);
                PORT1_IDX:
                    if (r.ws[0] && p1_wen)
                        n.p1d = r.wd[7:0];
                BUS_ADDR_IDX:
                begin
                    if (r.ws[0])
                        n.addr[7:0] = r.wd[7:0];
                    if (r.ws[1])
                        n.addr[15:8] = r.wd[15:8];
                end
                BUS_WDATA_IDX:
                    if (r.ws[0])
                        n.wdat = r.wd[7:0];
                BUS_CMD_IDX:
                    // A command during a cycle is refused, not queued
                    if (r.bs != BUS_IDLE || r.boot || r.wd[1:0] == KIND_BAD)
                        resp = RESP_SLVERR;
                    else if (r.ws[0])
                    begin
                        n.kind = r.wd[1:0];
                        n.dsp = r.wd[CMD_DSP];
                        n.stk = r.wd[CMD_STK];
                        n.ext = r.bus_port_mode_control[PM_EXT] && r.wd[1:0] != KIND_INT;
                        n.bs = BUS_T1;
                        n.ph = 1'b0;
                    end
                default: resp = RESP_SLVERR;
            endcase
            n.br = resp;
        end
        n.awrdy = ~n.aw_h;
        n.wrdy = ~n.w_h;

        // Register reads; mode registers are write only
        if (AXI_ARVALID_IN && r.arrdy)
        begin
            n.rv = 1'b1;
            n.rr = RESP_OKAY;
            n.rd = 16'h0000;
            case (AXI_ARADDR_IN[9:2])
                PORT0_IDX: n.rd[7:0] = p0_rd;
                PORT1_IDX: n.rd[7:0] = p1_rd;
                BUS_ADDR_IDX: n.rd = r.addr;
                BUS_WDATA_IDX: n.rd[7:0] = r.wdat;
                BUS_STAT_IDX: n.rd = {r.rdat, 7'h00, r.bs != BUS_IDLE};
                BUS_PORT_MODE_IDX: n.rd = 16'h0000;
                PORT3_MODE_IDX: n.rd = 16'h0000;
                default: n.rr = RESP_SLVERR;
            endcase
        end
        n.arrdy = ~n.rv;

        // Pins follow the next state so they leave flip-flops
        busy_n = n.bs != BUS_IDLE;
        ext_ref = n.kind != KIND_INT;
        shared = n.bus_port_mode_control[PM_BUS_HI:PM_BUS_LO] == SHARED_MODE;
        ad_mode = n.bus_port_mode_control[PM_BUS_HI:PM_BUS_LO] == AD_MODE;
        n.ctl_oe = ~shared;
        n.as_n = ~(n.bs == BUS_T1 && !n.ph);
        // Strobe low from mid T2 to end of T3, external only
        n.ds_n = ~(busy_n && ext_ref && ((n.bs == BUS_T2 && n.ph)
            || n.bs == BUS_TX || n.bs == BUS_T3));
        n.rw = ~(busy_n && n.kind == KIND_WR);
        n.dm_oe = n.p3m[P3_DM_HI:P3_DM_LO] == DM_SEL_A
            || n.p3m[P3_DM_HI:P3_DM_LO] == DM_SEL_B;
        n.dm_n = ~(busy_n && ext_ref && (n.dsp
            || (n.stk && !n.bus_port_mode_control[PM_STACK])));
        // Low port in bus mode 10: address in T1, write data after, else float
        n.ad_o = n.addr[7:0];
        n.ad_oe = 1'b0;
        if (ad_mode)
        begin
            if (busy_n && n.bs == BUS_T1)
                n.ad_oe = 1'b1;
            else if (busy_n && n.kind == KIND_WR)
            begin
                n.ad_oe = 1'b1;
                n.ad_o = n.wdat;
            end
        end
        else if (n.bus_port_mode_control[PM_BUS_HI:PM_BUS_LO] == IO_OUT)
        begin
            n.ad_oe = 1'b1;
            n.ad_o = n.p1d;
        end
        // Port 0 address nibbles hold the high address all cycle long; nibbles in mode 00 drive the port 0 output data
        n.p0_o = n.p0d;
        n.p0_oe = 8'h00;
        if (n.bus_port_mode_control[PM_P0LO_HI])
        begin
            n.p0_o[3:0] = n.addr[11:8];
            n.p0_oe[3:0] = {4{~shared}};
        end
        else if (n.bus_port_mode_control[PM_P0LO_HI:PM_P0LO_LO] == IO_OUT)
            n.p0_oe[3:0] = 4'hF;
        if (n.bus_port_mode_control[PM_P0HI_HI])
        begin
            n.p0_o[7:4] = n.addr[15:12];
            n.p0_oe[7:4] = {4{~shared}};
        end
        else if (n.bus_port_mode_control[PM_P0HI_HI:PM_P0HI_LO] == IO_OUT)
            n.p0_oe[7:4] = 4'hF;

        // Checking counters
        n.ds_cnt = n.ds_n ? 4'h0 : r.ds_cnt + 4'h1;
        n.cyc_cnt = (r.bs == BUS_IDLE) ? 4'h0 : r.cyc_cnt + 4'h1;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            r <= '0;
            r.awrdy <= 1'b1;
            r.wrdy <= 1'b1;
            r.arrdy <= 1'b1;
            r.bus_port_mode_control <= BUS_PORT_MODE_CONTROL_RST;
            r.p3m <= P3M_RST;
            r.addr <= RESET_VECTOR;
            r.boot <= 1'b1;
            r.as_n <= 1'b1;
            r.ds_n <= 1'b1;
            r.rw <= 1'b1;
            r.ctl_oe <= 1'b1;
            r.dm_n <= 1'b1;
        end
        else
            r <= n;
    end

    assign AXI_AWREADY_OUT = r.awrdy;
    assign AXI_WREADY_OUT = r.wrdy;
    assign AXI_BRESP_OUT = r.br;
    assign AXI_BVALID_OUT = r.bv;
    assign AXI_ARREADY_OUT = r.arrdy;
    assign AXI_RDATA_OUT = {16'h0000, r.rd};
    assign AXI_RRESP_OUT = r.rr;
    assign AXI_RVALID_OUT = r.rv;
    assign ADDR_STROBE_N_OUT = r.as_n;
    assign ADDR_STROBE_OE_OUT = r.ctl_oe;
    assign XFER_STROBE_N_OUT = r.ds_n;
    assign XFER_STROBE_OE_OUT = r.ctl_oe;
    assign READ_WRITE_N_OUT = r.rw;
    assign READ_WRITE_OE_OUT = r.ctl_oe;
    assign MUX_ADDR_DATA_BUS_OUT = r.ad_o;
    assign MUX_ADDR_DATA_BUS_OE_OUT = r.ad_oe;
    assign ADDR_PORT_OUT = r.p0_o;
    assign ADDR_PORT_OE_OUT = r.p0_oe;
    assign DATA_SPACE_SEL_N_OUT = r.dm_n;
    assign DATA_SPACE_SEL_OE_OUT = r.dm_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    sequence as_low_s;
        !r.as_n && r.bs == BUS_T1;
    endsequence
    sequence as_rise_s;
        r.as_n && r.bs == BUS_T1 && r.ph;
    endsequence

    as_pulse_a: assert property ((r.bs == BUS_T1 && !r.ph)
        |-> as_low_s ##1 as_rise_s)
        else $error("address strobe not low for one clock");
    bus_float_a: assert property (r.bus_port_mode_control[4:3] == SHARED_MODE
        |-> !r.ctl_oe && !r.ad_oe)
        else $error("bus driven in shared mode");
    wr_data_a: assert property (($fell(r.ds_n) && !r.rw
        && r.bus_port_mode_control[4:3] == AD_MODE)
        |-> r.ad_oe && r.ad_o == r.wdat && $past(r.ad_oe))
        else $error("write data not valid at strobe fall");
    rw_low_a: assert property (!r.rw
        |-> r.kind == KIND_WR && r.bs != BUS_IDLE)
        else $error("read/write low outside a write");
    boot_fetch_a: assert property ($fell(r.boot)
        |-> r.bs == BUS_T1 && r.addr == RESET_VECTOR)
        else $error("first fetch not at reset vector");
    rd_float_a: assert property (($fell(r.ds_n) && r.rw)
        |-> !r.ad_oe && !$past(r.ad_oe))
        else $error("bus driven at read strobe fall");
    ds_len_a: assert property ($rose(r.ds_n)
        |-> $past(r.ds_cnt) == (r.ext ? DS_EXT_CLKS : DS_CLKS))
        else $error("data strobe length wrong");
    cyc_len_a: assert property ((r.bs == BUS_IDLE
        && $past(r.bs) != BUS_IDLE)
        |-> r.cyc_cnt == (r.ext ? MC_EXT_CLKS : MC_CLKS))
        else $error("machine cycle length wrong");
    dm_sel_a: assert property (!r.dm_n
        |-> r.bs != BUS_IDLE && (r.dsp || (r.stk && !r.bus_port_mode_control[2])))
        else $error("data space select without data access");
    int_quiet_a: assert property ((r.bs != BUS_IDLE
        && r.kind == KIND_INT) |-> r.ds_n && r.rw)
        else $error("strobes active on internal access");
    p1_read_a: assert property ((AXI_ARVALID_IN && r.arrdy
        && AXI_ARADDR_IN[9:2] == PORT1_IDX && r.bus_port_mode_control[4])
        |=> r.rd[7:0] == BUS_READ_VAL)
        else $error("bus port read not all ones");

endmodule // xmb_ext_bus

`default_nettype wire

// ===== test/xmb_mem_model.sv
// Memory model on the far side of the external bus engine.
// Assumes strobes arrive as resolved pins with pull-ups.
`default_nettype none
module xmb_mem_model
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic as_n_in,
    input wire logic ds_n_in,
    input wire logic rw_n_in,
    input wire logic dm_n_in,
    input wire logic [7:0] ad_in,
    input wire logic [7:0] hi_in,
    output logic [7:0] ad_out,
    output logic [15:0] addr_out,
    output logic [7:0] wdat_out,
    output logic rw_out,
    output logic dm_out,
    output logic [3:0] ds_len_out,
    output logic [7:0] n_ds_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic as_q, ds_q;
    // Data from address; released bus shows its inverse, never old data
    assign ad_out = (!ds_n_in && rw_n_in) ? addr_out[7:0] ^ 8'h3C
                                          : ~(addr_out[7:0] ^ 8'h3C);
    // Latch at address strobe rise, capture write data at strobe fall
    always @(posedge clk_in)
    begin
        as_q <= as_n_in;
        ds_q <= ds_n_in;
        if (rst_in)
            n_ds_out <= 8'h00;
        else if (!ds_n_in && ds_q)
            n_ds_out <= n_ds_out + 8'h01;
        if (as_n_in && !as_q)
            {addr_out, rw_out, dm_out} <= {hi_in, ad_in, rw_n_in, dm_n_in};
        if (!ds_n_in && ds_q)
            {wdat_out, ds_len_out} <= {ad_in, 4'h1};
        else if (!ds_n_in)
            ds_len_out <= ds_len_out + 4'h1;
    end
endmodule // xmb_mem_model
`default_nettype wire

// ===== test/xmb_ext_bus_tb.sv
// Bench for the external bus engine through AXI4-Lite.
// Assumes the memory model and pull-ups on released strobes.
`default_nettype none
module xmb_ext_bus_tb;
    import xmb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0;
    logic arv = 1'b0, rre = 1'b0;
    logic [9:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdat;
    logic [7:0] p0_drv = 8'h00, ad_o, p0_o, p0_oe, ad_m, m_wd, m_nds;
    logic awr, wrdy, bv, arr, rv, oe_s, ad_oe, as_o, ds_o, rw_o, dm_o;
    logic dm_oe, m_rw, m_dm;
    logic [1:0] br;
    logic [15:0] m_addr;
    logic [3:0] m_len;
    int mismatches = 0, n_checks = 0, cyc = 0;
    // Released strobes float to the pull-up level
    wire logic as_p = oe_s ? as_o : 1'b1;
    wire logic ds_p = oe_s ? ds_o : 1'b1;
    wire logic rw_p = oe_s ? rw_o : 1'b1;
    wire logic dm_p = dm_oe ? dm_o : 1'b1;
    wire logic [7:0] ad_p = ad_oe ? ad_o : ad_m;
    wire logic [7:0] p0_p = (p0_oe & p0_o) | (~p0_oe & p0_drv);
    xmb_ext_bus i_xmb_ext_bus (.CLK_IN(clk), .SYS_RST_IN(rst),
        .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
        .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'h3), .AXI_WVALID_IN(wv),
        .AXI_WREADY_OUT(wrdy), .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv),
        .AXI_BREADY_IN(bre), .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv),
        .AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(),
        .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rre),
        .ADDR_STROBE_N_OUT(as_o), .ADDR_STROBE_OE_OUT(oe_s),
        .XFER_STROBE_N_OUT(ds_o), .XFER_STROBE_OE_OUT(),
        .READ_WRITE_N_OUT(rw_o), .READ_WRITE_OE_OUT(),
        .MUX_ADDR_DATA_BUS_IN(ad_p), .MUX_ADDR_DATA_BUS_OUT(ad_o),
        .MUX_ADDR_DATA_BUS_OE_OUT(ad_oe), .ADDR_PORT_IN(p0_p),
        .ADDR_PORT_OUT(p0_o), .ADDR_PORT_OE_OUT(p0_oe),
        .DATA_SPACE_SEL_N_OUT(dm_o), .DATA_SPACE_SEL_OE_OUT(dm_oe));
    xmb_mem_model i_xmb_mem_model (.clk_in(clk), .rst_in(rst),
        .as_n_in(as_p), .ds_n_in(ds_p), .rw_n_in(rw_p), .dm_n_in(dm_p),
        .ad_in(ad_p), .hi_in(p0_p), .ad_out(ad_m), .addr_out(m_addr),
        .wdat_out(m_wd), .rw_out(m_rw), .dm_out(m_dm),
        .ds_len_out(m_len), .n_ds_out(m_nds));
    always #10 clk = ~clk;
    // Hang guard, far above the hundred or so cycles the tests need
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks = n_checks + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Address and data offered together, each dropped when taken
    task automatic wrc(input logic [7:0] i, input logic [15:0] d,
                       input logic [1:0] e);
        @(posedge clk);
        {awa, wd} <= {i, 2'b00, 16'h0000, d};
        {awv, wv, bre} <= 3'b111;
        do
        begin
            @(posedge clk);
            if (awr === 1'b1)
                awv <= 1'b0;
            if (wrdy === 1'b1)
                wv <= 1'b0;
        end while (awv || wv);
        do @(posedge clk); while (bv !== 1'b1);
        chk("bresp", {14'h0000, e}, {14'h0000, br});
        bre <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, output logic [15:0] d);
        @(posedge clk);
        ara <= {i, 2'b00};
        {arv, rre} <= 2'b11;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        d = rdat[15:0];
        rre <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] i, input logic [15:0] e,
                       input string nm);
        logic [15:0] v;
        rd(i, v);
        chk(nm, e, v);
    endtask
    // Start one bus cycle, then poll status until it is idle
    task automatic go(input logic [15:0] c, output logic [15:0] v);
        wrc(BUS_CMD_IDX, c, RESP_OKAY);
        v = 16'h0001;
        for (int k = 0; k < 50 && v[0] !== 1'b0; k++)
            rd(BUS_STAT_IDX, v);
        chk("busy", 16'h0000, {15'h0000, v[0]});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [15:0] s;
        logic [7:0] n8;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(BUS_ADDR_IDX, RESET_VECTOR, "boot");
        wrc(PORT3_MODE_IDX, 16'h0010, RESP_OKAY);
        chk("dm_oe", 16'h0001, {15'h0000, dm_oe});
        wrc(BUS_PORT_MODE_IDX, 16'h00B2, RESP_OKAY);
        rdc(PORT1_IDX, 16'h00FF, "port1");
        rdc(PORT0_IDX, 16'h00FF, "port0");
        wrc(BUS_ADDR_IDX, 16'h1234, RESP_OKAY);
        wrc(BUS_WDATA_IDX, 16'h005A, RESP_OKAY);
        go(16'h0006, s);
        chk("addr", 16'h1234, m_addr);
        chk("wdata", 16'h005A, {8'h00, m_wd});
        chk("rw_wr", 16'h0000, {15'h0000, m_rw});
        chk("dm", 16'h0000, {15'h0000, m_dm});
        chk("ds_ext", {12'h000, DS_EXT_CLKS}, {12'h000, m_len});
        go(16'h0005, s);
        chk("rdata", 16'h0008, {8'h00, s[15:8]});
        chk("rw_rd", 16'h0001, {15'h0000, m_rw});
        wrc(BUS_PORT_MODE_IDX, 16'h0092, RESP_OKAY);
        go(16'h0002, s);
        chk("ds", {12'h000, DS_CLKS}, {12'h000, m_len});
        n8 = m_nds;
        go(16'h0000, s);
        chk("ds_int", {8'h00, n8}, {8'h00, m_nds});
        wrc(BUS_CMD_IDX, 16'h0003, RESP_SLVERR);
        wrc(8'h20, 16'h0000, RESP_SLVERR);
        p0_drv <= 8'hA5;
        wrc(BUS_PORT_MODE_IDX, 16'h0052, RESP_OKAY);
        repeat (4) @(posedge clk); // Pins pass the synchroniser
        rdc(PORT0_IDX, 16'h00AF, "port0_half");
        wrc(BUS_PORT_MODE_IDX, 16'h0018, RESP_OKAY);
        chk("float", 16'h0000, {14'h0000, oe_s, ad_oe});
        conclude();
    end
endmodule // xmb_ext_bus_tb
`default_nettype wire
